// file: rtl/ramdac_front.sv
// host port, frequency select latch and pixel port of the palette dac
//
// Notes on behaviour
// - register select is captured when the active strobe falls.
// - write data is taken at the write strobe rise into selected register.
// - host data bus is eight bits wide, both directions, strobe governed.
// - read drives the addressed register; bus released once read strobe rises.
// - host accesses are asynchronous; host spaces them by system clock periods.
// - four select inputs pick video frequency unless register control selects it.
// - select inputs are latched on the falling edge of the latch strobe.
// - pixel word, blanking and mode mix sampled on rising pixel clock.
// - with extended modes, mix low selects primary, high selects secondary.
// - sampled blanking low turns colour outputs off after pipeline delay.
// - pixel word is interpreted by the currently selected pixel mode.
// - two base plus fourteen standard frequencies, each reprogrammable by host.
// - third select bit reaches extended registers directly.
// - select codes map to palette, mask, index, indexed and command registers.
// - combined index increments after every indexed register access.
`timescale 1ns/1ps
`include "ramdac_front_consts.svh"

// ************************************************************
// pixel fifo
// ************************************************************
module pixel_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  always_comb begin
    push        = in_valid_in && in_ready_out;
    pop         = out_valid_out && out_ready_in;
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

// ************************************************************
// top
// ************************************************************
module ramdac_front #(
  parameter int FIFO_DEPTH = 32,
  parameter int IDX_DEPTH  = 32
) (
  input  wire logic                              SYS_CLK_IN,
  input  wire logic                              RESETN_IN,
  input  wire logic                              RD_N_IN,
  input  wire logic                              WR_N_IN,
  input  wire logic [2:0]                        REG_SELECT_IN,
  input  wire logic [7:0]                        HOST_DATA_BUS_IN,
  output logic      [7:0]                        HOST_DATA_BUS_OUT,
  output logic                                   HOST_DATA_BUS_OE_OUT,
  input  wire logic [3:0]                        CLK_FREQ_SELECT_IN,
  input  wire logic                              FREQ_LATCH_N_IN,
  output logic      [3:0]                        VCLK_FREQ_CODE_OUT,
  output logic      [7:0]                        VCLK_FREQ_WORD_OUT,
  input  wire logic                              PIXEL_CLK_IN,
  input  wire ramdac_front_pkg::pixel_sample_type PIXEL_SAMPLE_IN,
  output logic                                   PIXEL_READY_OUT,
  input  wire logic                              DAC_READY_IN,
  output logic      [23:0]                       RGB_OUT,
  output logic                                   RGB_VALID_OUT,
  output logic                                   DAC_ON_OUT
);
  import ramdac_front_pkg::*;

  // ************************************************************
  // pin synchronisers, host domain
  // ************************************************************
  // strobes and data all pass two flops; host spacing keeps data settled
  // spacing covers sync lag
  logic [1:0] rd_meta;
  logic [1:0] wr_meta;
  logic [1:0] lat_meta;
  logic [2:0] rs_meta;
  logic [2:0] rs_sync;
  logic [7:0] data_meta;
  logic [7:0] data_sync;
  logic [3:0] vs_meta;
  logic [3:0] vs_sync;
  logic       rd_sync;
  logic       wr_sync;
  logic       lat_sync;
  logic       rd_last;
  logic       wr_last;
  logic       lat_last;

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_meta   <= 2'h3;
      wr_meta   <= 2'h3;
      lat_meta  <= 2'h3;
      rs_meta   <= 3'h0;
      rs_sync   <= 3'h0;
      data_meta <= 8'h00;
      data_sync <= 8'h00;
      vs_meta   <= 4'h0;
      vs_sync   <= 4'h0;
      rd_last   <= 1'b1;
      wr_last   <= 1'b1;
      lat_last  <= 1'b1;
    end else begin
      rd_meta   <= {rd_meta[0], RD_N_IN};
      wr_meta   <= {wr_meta[0], WR_N_IN};
      lat_meta  <= {lat_meta[0], FREQ_LATCH_N_IN};
      rs_meta   <= REG_SELECT_IN;
      rs_sync   <= rs_meta;
      data_meta <= HOST_DATA_BUS_IN;
      data_sync <= data_meta;
      vs_meta   <= CLK_FREQ_SELECT_IN;
      vs_sync   <= vs_meta;
      rd_last   <= rd_sync;
      wr_last   <= wr_sync;
      lat_last  <= lat_sync;
    end
  end

  assign rd_sync  = rd_meta[1];
  assign wr_sync  = wr_meta[1];
  assign lat_sync = lat_meta[1];

  // ************************************************************
  // host register file
  // ************************************************************
  host_state_type state;
  host_state_type next_state;
  logic [2:0]     sel;
  logic [2:0]     next_sel;
  logic           oe;
  logic           next_oe;
  logic [7:0]     dout;
  logic [7:0]     next_dout;
  logic [7:0]     pal_waddr;
  logic [7:0]     next_pal_waddr;
  logic [7:0]     pal_raddr;
  logic [7:0]     next_pal_raddr;
  logic [7:0]     pal_color;
  logic [7:0]     next_pal_color;
  logic [15:0]    index;
  logic [15:0]    next_index;
  logic [7:0]     idx_mem [IDX_DEPTH];
  logic [7:0]     next_idx_mem [IDX_DEPTH];
  logic [3:0]     vs_latched;
  logic [3:0]     next_vs_latched;
  logic [3:0]     freq_code;
  logic [3:0]     next_freq_code;
  logic [7:0]     freq_word;
  logic [7:0]     next_freq_word;
  pixel_cfg_type  cfg_hold;
  pixel_cfg_type  next_cfg_hold;
  logic           cfg_toggle;
  logic           next_cfg_toggle;
  logic           rd_fall;
  logic           wr_fall;
  logic           access_end;
  logic [4:0]     idx_slot;
  logic [7:0]     clk_ctrl;

  assign rd_fall  = rd_last && !rd_sync;
  assign wr_fall  = wr_last && !wr_sync;
  assign idx_slot = index[4:0];
  assign clk_ctrl = idx_mem[`IDX_CLK_CTRL];

  always_comb begin
    next_state      = state;
    next_sel        = sel;
    next_oe         = oe;
    next_dout       = dout;
    next_pal_waddr  = pal_waddr;
    next_pal_raddr  = pal_raddr;
    next_pal_color  = pal_color;
    next_index      = index;
    next_idx_mem    = idx_mem;
    next_cfg_hold   = cfg_hold;
    next_cfg_toggle = cfg_toggle;
    access_end      = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (rd_fall) begin
          next_sel   = rs_sync;
          next_state = ST_READ;
          next_oe    = 1'b1;
          unique case (rs_sync)
            `RS_PAL_WADDR: next_dout = pal_waddr;
            `RS_PAL_COLOR: next_dout = pal_color;
            `RS_PIX_MASK:  next_dout = cfg_hold.mask;
            `RS_PAL_RADDR: next_dout = pal_raddr;
            `RS_INDEX_LO:  next_dout = index[7:0];
            `RS_INDEXED:   next_dout = idx_mem[idx_slot];
            `RS_PIX_CMD:   next_dout = cfg_hold.cmd;
            `RS_INDEX_HI:  next_dout = index[15:8];
          endcase
        end else if (wr_fall) begin
          next_sel   = rs_sync;
          next_state = ST_WRITE;
        end
      end
      ST_READ: begin
        // release bus once read strobe rises
        if (rd_sync) begin
          next_oe    = 1'b0;
          next_state = ST_IDLE;
          access_end = 1'b1;
        end
      end
      ST_WRITE: begin
        // data taken at write strobe rise
        if (wr_sync) begin
          next_state = ST_IDLE;
          access_end = 1'b1;
          unique case (sel)
            `RS_PAL_WADDR: next_pal_waddr = data_sync;
            `RS_PAL_COLOR: next_pal_color = data_sync;
            `RS_PIX_MASK:  next_cfg_hold.mask = data_sync;
            `RS_PAL_RADDR: next_pal_raddr = data_sync;
            `RS_INDEX_LO:  next_index[7:0] = data_sync;
            `RS_INDEXED:   next_idx_mem[idx_slot] = data_sync;
            `RS_PIX_CMD:   next_cfg_hold.cmd = data_sync;
            `RS_INDEX_HI:  next_index[15:8] = data_sync;
          endcase
          if (sel == `RS_PIX_MASK || sel == `RS_PIX_CMD) begin
            next_cfg_toggle = !cfg_toggle;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_oe    = 1'b0;
      end
    endcase
    if (access_end && sel == `RS_INDEXED) begin
      next_index = index + `INDEX_STEP;
    end
  end

  // ************************************************************
  // video clock select
  // ************************************************************
  always_comb begin
    next_vs_latched = vs_latched;
    if (lat_last && !lat_sync) begin
      next_vs_latched = vs_sync;
    end
    if (clk_ctrl[`CLK_REG_BIT]) begin
      next_freq_code = clk_ctrl[`CLK_CODE_LSB +: 4];
    end else begin
      next_freq_code = vs_latched;
    end
    // sixteen codes, each with a host programmable word
    next_freq_word = idx_mem[{`FREQ_TABLE_SEL, freq_code}];
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state      <= ST_IDLE;
      sel        <= 3'h0;
      oe         <= 1'b0;
      dout       <= `BYTE_ZERO;
      pal_waddr  <= `BYTE_ZERO;
      pal_raddr  <= `BYTE_ZERO;
      pal_color  <= `BYTE_ZERO;
      index      <= `INDEX_RESET;
      idx_mem    <= '{default: `BYTE_ZERO};
      cfg_hold   <= '{cmd: `CMD_RESET, mask: `MASK_RESET};
      cfg_toggle <= 1'b0;
      vs_latched <= `FREQ_RESET;
      freq_code  <= `FREQ_RESET;
      freq_word  <= `BYTE_ZERO;
    end else begin
      state      <= next_state;
      sel        <= next_sel;
      oe         <= next_oe;
      dout       <= next_dout;
      pal_waddr  <= next_pal_waddr;
      pal_raddr  <= next_pal_raddr;
      pal_color  <= next_pal_color;
      index      <= next_index;
      idx_mem    <= next_idx_mem;
      cfg_hold   <= next_cfg_hold;
      cfg_toggle <= next_cfg_toggle;
      vs_latched <= next_vs_latched;
      freq_code  <= next_freq_code;
      freq_word  <= next_freq_word;
    end
  end

  // eight bit bus, driven only during reads
  assign HOST_DATA_BUS_OUT    = dout;
  assign HOST_DATA_BUS_OE_OUT = oe;
  assign VCLK_FREQ_CODE_OUT   = freq_code;
  assign VCLK_FREQ_WORD_OUT   = freq_word;

  // ************************************************************
  // settings crossing, pixel domain
  // ************************************************************
  logic [1:0]    tog_meta;
  logic          tog_last;
  pixel_cfg_type cfg_pix;
  pixel_cfg_type next_cfg_pix;
  logic          tog_change;

  // hold is stable for two pixel clocks before the toggle is seen
  always_comb begin
    tog_change   = tog_meta[1] != tog_last;
    next_cfg_pix = tog_change ? cfg_hold : cfg_pix;
  end

  always_ff @(posedge PIXEL_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tog_meta <= 2'h0;
      tog_last <= 1'b0;
      cfg_pix  <= '{cmd: `CMD_RESET, mask: `MASK_RESET};
    end else begin
      tog_meta <= {tog_meta[0], cfg_toggle};
      tog_last <= tog_meta[1];
      cfg_pix  <= next_cfg_pix;
    end
  end

  // ************************************************************
  // pixel path
  // ************************************************************
  function automatic logic [23:0] decode(input logic [15:0] w, input pix_mode_type m,
                                         input logic [7:0] mask);
    logic [7:0] idx;
    idx = w[7:0] & mask;
    unique case (m)
      MODE_INDEX8: decode = {idx, idx, idx};
      MODE_RGB555: decode = {w[14:10], 3'h0, w[9:5], 3'h0, w[4:0], 3'h0};
      MODE_RGB565: decode = {w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0};
      MODE_DIRECT: decode = {w[15:8], w[7:0], 8'h00};
    endcase
  endfunction

  pixel_sample_type sample;
  pixel_sample_type head;
  logic             in_ready;
  logic             out_valid;
  logic             pop;
  pix_mode_type     mode;
  logic [23:0]      rgb;
  logic [23:0]      next_rgb;
  logic             rgb_valid;
  logic             next_rgb_valid;
  logic             dac_on;
  logic             next_dac_on;
  logic             ready;

  // pixel sample pins registered on the rising pixel clock; dac ready is used unregistered
  always_ff @(posedge PIXEL_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sample <= '0;
      ready  <= 1'b0;
    end else begin
      sample <= PIXEL_SAMPLE_IN;
      ready  <= in_ready;
    end
  end

  // samples arriving while full are dropped; ready tells the source
  pixel_fifo #(
    .WIDTH ($bits(pixel_sample_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (PIXEL_CLK_IN),
    .resetn_in     (RESETN_IN),
    .in_valid_in   (1'b1),
    .in_ready_out  (in_ready),
    .in_data_in    (sample),
    .out_valid_out (out_valid),
    .out_ready_in  (DAC_READY_IN),
    .out_data_out  (head)
  );

  always_comb begin
    pop = out_valid && DAC_READY_IN;
    // mix chooses secondary mode only when extended
    if (cfg_pix.cmd[`CMD_EXT_BIT] && head.mix) begin
      mode = pix_mode_type'(cfg_pix.cmd[`CMD_SEC_LSB +: 2]);
    end else begin
      mode = pix_mode_type'(cfg_pix.cmd[`CMD_PRI_LSB +: 2]);
    end
    next_rgb       = rgb;
    next_rgb_valid = pop;
    next_dac_on    = dac_on;
    if (pop) begin
      next_rgb    = decode(head.word, mode, cfg_pix.mask);
      // blank travels the pipe with its pixel
      next_dac_on = head.blank_n;
    end
  end

  always_ff @(posedge PIXEL_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rgb       <= 24'h000000;
      rgb_valid <= 1'b0;
      dac_on    <= 1'b0;
    end else begin
      rgb       <= next_rgb;
      rgb_valid <= next_rgb_valid;
      dac_on    <= next_dac_on;
    end
  end

  assign PIXEL_READY_OUT = ready;
  assign RGB_OUT         = rgb;
  assign RGB_VALID_OUT   = rgb_valid;
  assign DAC_ON_OUT      = dac_on;

  // ************************************************************
  // checks
  // ************************************************************
  sel_capture_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    state == ST_IDLE && (rd_fall || wr_fall) |=> sel == $past(rs_sync))
    else $error("select not captured at strobe fall");
  cmd_write_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    state == ST_WRITE && wr_sync && sel == `RS_PIX_CMD |=> cfg_hold.cmd == $past(data_sync))
    else $error("command write lost");
  read_drive_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    state == ST_IDLE && rd_fall |=> oe ##0 (oe throughout (!rd_sync)[*1]))
    else $error("read did not drive bus");
  bus_release_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    state == ST_READ && rd_sync |=> !oe && state == ST_IDLE)
    else $error("bus not released");
  index_step_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    access_end && sel == `RS_INDEXED |=> index == $past(index) + `INDEX_STEP)
    else $error("index did not step");
  reg_ctrl_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    clk_ctrl[`CLK_REG_BIT] && $stable(clk_ctrl) |=> freq_code == $past(clk_ctrl[4:1]))
    else $error("pins not ignored under register control");
  vs_latch_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    lat_last && !lat_sync |=> vs_latched == $past(vs_sync))
    else $error("select pins not latched");
  cfg_cross_a: assert property (@(posedge PIXEL_CLK_IN) disable iff (!RESETN_IN)
    tog_change |=> cfg_pix == $past(cfg_hold))
    else $error("settings not carried across");
  blank_off_a: assert property (@(posedge PIXEL_CLK_IN) disable iff (!RESETN_IN)
    pop && !head.blank_n |=> !DAC_ON_OUT && RGB_VALID_OUT)
    else $error("blank did not turn outputs off");
  mix_mode_a: assert property (@(posedge PIXEL_CLK_IN) disable iff (!RESETN_IN)
    !cfg_pix.cmd[`CMD_EXT_BIT] |-> mode == pix_mode_type'(cfg_pix.cmd[1:0]))
    else $error("mix acted without extended modes");
endmodule

// file: rtl/ramdac_front_consts.svh
// constant definitions for the palette dac front end
`ifndef RAMDAC_FRONT_CONSTS_SVH
`define RAMDAC_FRONT_CONSTS_SVH

// ************************************************************
// register select codes
// ************************************************************
`define RS_PAL_WADDR   3'h0
`define RS_PAL_COLOR   3'h1
`define RS_PIX_MASK    3'h2
`define RS_PAL_RADDR   3'h3
`define RS_INDEX_LO    3'h4
`define RS_INDEXED     3'h5
`define RS_PIX_CMD     3'h6
`define RS_INDEX_HI    3'h7

// ************************************************************
// reset values and fields
// ************************************************************
`define MASK_RESET     8'hFF
`define CMD_RESET      8'h00
`define BYTE_ZERO      8'h00
`define INDEX_RESET    16'h0000
`define INDEX_STEP     16'h0001
`define IDX_CLK_CTRL   5'h00
`define CLK_REG_BIT    0
`define CLK_CODE_LSB   1
`define FREQ_TABLE_SEL 1'b1
`define CMD_EXT_BIT    7
`define CMD_PRI_LSB    0
`define CMD_SEC_LSB    2
`define FREQ_RESET     4'h0

`endif

// file: rtl/ramdac_front_pkg.sv
// types shared by the palette dac front end
package ramdac_front_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } host_state_type;

  typedef enum logic [1:0] {
    MODE_INDEX8 = 2'b00,
    MODE_RGB555 = 2'b01,
    MODE_RGB565 = 2'b10,
    MODE_DIRECT = 2'b11
  } pix_mode_type;

  typedef struct packed {
    logic        mix;
    logic        blank_n;
    logic [15:0] word;
  } pixel_sample_type;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] mask;
  } pixel_cfg_type;

endpackage

// file: testbench/host_bus_model.sv
// graphics controller model driving the host bus and frequency pins
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_in,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic [2:0]      sel_out,
  output logic [7:0]      bus_out,
  output logic [3:0]      freq_out,
  output logic            latch_n_out
);
  logic       drive = 1'b0;
  logic [7:0] drv   = 8'h00;
  logic [7:0] last  = 8'h00;
  // ****
  // bus wire
  // ****
  // released bus shows a moving pattern, never a stale value
  assign bus_out = dev_oe_in ? dev_data_in : (drive ? drv : ~last);
  always @(posedge clk_in) last <= bus_out;
  initial begin
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    sel_out = 3'h0;
    freq_out = 4'h0;
    latch_n_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // one strobe at a time, spaced; data settles late
  task automatic write_reg(input logic [2:0] sel, input logic [7:0] data);
    sel_out = sel;
    drv = ~data;
    drive = 1'b1;
    wr_n_out = 1'b0;
    tick(4);
    drv = data;
    sel_out = ~sel;
    tick(4);
    wr_n_out = 1'b1;
    tick(4);
    drive = 1'b0;
    tick(8);
  endtask
  // select moves after the fall, so late capture shows
  task automatic read_reg(input logic [2:0] sel, output logic [7:0] data,
                          output logic oe_low, output logic oe_high);
    sel_out = sel;
    rd_n_out = 1'b0;
    tick(4);
    sel_out = ~sel;
    tick(4);
    data = dev_data_in;
    oe_low = dev_oe_in;
    rd_n_out = 1'b1;
    tick(8);
    oe_high = dev_oe_in;
  endtask
  task automatic latch_freq(input logic [3:0] code);
    freq_out = code;
    tick(4);
    latch_n_out = 1'b0;
    tick(4);
    freq_out = ~code;
    tick(4);
    latch_n_out = 1'b1;
    tick(8);
  endtask
endmodule

// file: testbench/tb_ramdac_front.sv
// self-checking testbench of the palette dac front end
`timescale 1ns/1ps
`include "ramdac_front_consts.svh"
module tb_ramdac_front;
  import ramdac_front_pkg::*;
  typedef struct packed {
    logic        cmp;
    logic        on;
    logic [23:0] rgb;
  } exp_type;
  logic             sys_clk     = 1'b0;
  logic             pclk        = 1'b0;
  logic             resetn      = 1'b0;
  logic             dac_rdy     = 1'b1;
  logic             feed        = 1'b0;
  logic             settled     = 1'b0;
  logic             syncing     = 1'b1;
  logic [7:0]       cur_cmd     = 8'h00;
  logic [7:0]       cur_mask    = 8'hFF;
  logic [7:0]       cmds[5]     = '{8'h00, 8'h83, 8'h03, 8'h8C, 8'h89};
  logic [7:0]       masks[5]    = '{8'hFF, 8'h0F, 8'hFF, 8'h3C, 8'hFF};
  pixel_sample_type pin         = 18'h10000;
  int               n_errors    = 0;
  int               check_count = 0;
  int               seed        = 32'hEFC8895A;
  int               w;
  exp_type          expq[$];
  exp_type          e;
  exp_type          got;
  logic             rd_n, wr_n, latch_n, oe, rgb_valid, dac_on, pix_ready;
  logic [2:0]       sel;
  logic [3:0]       fsel, fcode;
  logic [7:0]       bus, dout, fword, v;
  logic [23:0]      rgb;
  always #2.5 sys_clk = ~sys_clk;
  always #80 pclk = ~pclk;
  host_bus_model host_bus_model_i (
    .clk_in      (sys_clk),
    .dev_data_in (dout),
    .dev_oe_in   (oe),
    .rd_n_out    (rd_n),
    .wr_n_out    (wr_n),
    .sel_out     (sel),
    .bus_out     (bus),
    .freq_out    (fsel),
    .latch_n_out (latch_n)
  );
  ramdac_front ramdac_front_i (
    .SYS_CLK_IN           (sys_clk),
    .RESETN_IN            (resetn),
    .RD_N_IN              (rd_n),
    .WR_N_IN              (wr_n),
    .REG_SELECT_IN        (sel),
    .HOST_DATA_BUS_IN     (bus),
    .HOST_DATA_BUS_OUT    (dout),
    .HOST_DATA_BUS_OE_OUT (oe),
    .CLK_FREQ_SELECT_IN   (fsel),
    .FREQ_LATCH_N_IN      (latch_n),
    .VCLK_FREQ_CODE_OUT   (fcode),
    .VCLK_FREQ_WORD_OUT   (fword),
    .PIXEL_CLK_IN         (pclk),
    .PIXEL_SAMPLE_IN      (pin),
    .PIXEL_READY_OUT      (pix_ready),
    .DAC_READY_IN         (dac_rdy),
    .RGB_OUT              (rgb),
    .RGB_VALID_OUT        (rgb_valid),
    .DAC_ON_OUT           (dac_on)
  );
  task automatic check(input logic [23:0] act, input logic [23:0] exp);
    check_count++;
    if (act !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    host_bus_model_i.write_reg(s, d);
  endtask
  task automatic rd_check(input logic [2:0] s, input logic [7:0] exp);
    logic [7:0] d;
    logic       oe_low, oe_high;
    host_bus_model_i.read_reg(s, d, oe_low, oe_high);
    check(24'(d), 24'(exp));
    // driven during the read, released after it
    check(24'(oe_low), 24'h1);
    check(24'(oe_high), 24'h0);
  endtask
  task automatic pix_wait(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // mode picked by mix only when extended modes are on
  function automatic logic [23:0] exp_rgb(input pixel_sample_type s);
    logic [1:0]  m;
    logic [15:0] x;
    m = (cur_cmd[`CMD_EXT_BIT] && s.mix) ? cur_cmd[3:2] : cur_cmd[1:0];
    x = s.word;
    case (m)
      2'h1: return {x[14:10], 3'h0, x[9:5], 3'h0, x[4:0], 3'h0};
      2'h2: return {x[15:11], 3'h0, x[10:5], 2'h0, x[4:0], 3'h0};
      2'h3: return {x, 8'h00};
      default: return {3{x[7:0] & cur_mask}};
    endcase
  endfunction
  // ****
  // pixel stream and result watch
  // ****
  always @(posedge pclk) begin
    #1;
    if (feed) begin
      pin = 18'($random(seed));
      pin.blank_n = ($random(seed) % 8) != 0;
      // a blanked first sample cannot pass for warm-up in any mode or mask
      if (syncing)
        pin.blank_n = 1'b0;
      e.cmp = settled;
      e.on = pin.blank_n;
      e.rgb = exp_rgb(pin);
      expq.push_back(e);
    end
  end
  // warm-up results are zero with outputs on; skipped until the first fed one
  // looked at mid-cycle, where the registered outputs are settled
  always @(negedge pclk) begin
    if (feed && rgb_valid === 1'b1 && !(syncing && dac_on === 1'b1 && rgb === 24'h0)) begin
      syncing = 1'b0;
      if (expq.size() == 0)
        check(24'h0, 24'h1);
      else begin
        got = expq.pop_front();
        if (got.cmp) begin
          check(24'(dac_on), 24'(got.on));
          if (got.on)
            check(rgb, got.rgb);
        end
      end
    end
  end
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    repeat (2) @(posedge pclk);
    #1;
    check(24'(oe), 24'h0);
    check(24'(fcode), 24'(`FREQ_RESET));
    resetn = 1'b1;
    pix_wait(1);
    rd_check(`RS_PIX_MASK, `MASK_RESET);
    rd_check(`RS_PIX_CMD, `CMD_RESET);
    for (int s = 0; s < 8; s++) begin
      if (s != 5) begin
        v = 8'($random(seed));
        wr(3'(s), v);
        rd_check(3'(s), v);
        pix_wait(5);
      end
    end
    wr(`RS_INDEX_HI, 8'h00);
    wr(`RS_INDEX_LO, 8'h15);
    wr(`RS_INDEXED, 8'h5A);
    rd_check(`RS_INDEX_LO, 8'h16);
    wr(`RS_INDEX_LO, 8'h15);
    rd_check(`RS_INDEXED, 8'h5A);
    rd_check(`RS_INDEX_LO, 8'h16);
    host_bus_model_i.latch_freq(4'h5);
    check(24'(fcode), 24'h5);
    check(24'(fword), 24'h5A);
    wr(`RS_INDEX_LO, 8'h00);
    wr(`RS_INDEXED, 8'h13);
    host_bus_model_i.latch_freq(4'h2);
    check(24'(fcode), 24'h9);
    feed = 1'b1;
    for (int b = 0; b < 5; b++) begin
      settled = 1'b0;
      pix_wait(5);
      wr(`RS_PIX_MASK, masks[b]);
      pix_wait(5);
      wr(`RS_PIX_CMD, cmds[b]);
      cur_mask = masks[b];
      cur_cmd = cmds[b];
      pix_wait(6);
      settled = 1'b1;
      pix_wait(24);
    end
    // stall the drain so the buffer fills and refuses
    feed = 1'b0;
    dac_rdy = 1'b0;
    w = 0;
    while (pix_ready !== 1'b0 && w < 40) begin
      pix_wait(1);
      w++;
    end
    check(24'(pix_ready), 24'h0);
    check(24'(rgb_valid), 24'h0);
    dac_rdy = 1'b1;
    w = 0;
    while (rgb_valid !== 1'b1 && w < 5) begin
      pix_wait(1);
      w++;
    end
    check(24'(rgb_valid), 24'h1);
    stop_test();
  end
endmodule
